/* File: verilog/scvox_pkg.sv */
// constants and register map of the speech codec vox and transfer control
// How it works
// - one power value per 9 ms slice
// - segment length from 11-bit slice count
// - frame length 7-bit; noise flag judged per frame
// - segment spread is max minus min power
// - count slices above 15-bit energy limit
// - too few loud slices means quiet segment
// - loud segment: small spread quiet, else voice
// - enough adjacent voice clears flag, restarts frame
// - few quiet, enough voice clears flag, timer
// - otherwise timer counts; reaching time sets flag
// - serial mode: coded word stored, available raised
// - host reads word; read clears available flag
// - serial format overhead 0.4 or 0.2 kbit/s
// - decoder gives continuous 128 kbit/s sample stream
// - speeds 1.5, 2.0, 0.5 scale request rate
// - skipped gap replays as one 30 ms block
// - gap replays silence or level-scaled comfort noise
// - end of file clears decoder enable
// - final 90 ms of file not played
// - request flag raised; input word write clears
package scvox_pkg;
  // register indices on the register port
  localparam logic [3:0] SCVOX_IDX_FRAME_CFG = 4'h0;
  localparam logic [3:0] SCVOX_IDX_FRAME_THR = 4'h1;
  localparam logic [3:0] SCVOX_IDX_ENERGY = 4'h2;
  localparam logic [3:0] SCVOX_IDX_SPREAD = 4'h3;
  localparam logic [3:0] SCVOX_IDX_SEG_TIMER = 4'h4;
  localparam logic [3:0] SCVOX_IDX_SEG_LEN = 4'h5;
  localparam logic [3:0] SCVOX_IDX_DEC_CTRL = 4'h6;
  localparam logic [3:0] SCVOX_IDX_FLAGS = 4'h7;
  localparam logic [3:0] SCVOX_IDX_CODER_WORD = 4'h8;
  localparam logic [3:0] SCVOX_IDX_NOISE_LVL = 4'h9;
  localparam logic [3:0] SCVOX_IDX_DEC_WORD = 4'hA;
  localparam logic [3:0] SCVOX_IDX_VOX_STATUS = 4'hB;
  // field positions: two 7-bit fields share a 14-bit register
  localparam int SCVOX_LO7 = 0;
  localparam int SCVOX_HI7 = 7;
  // decoder control bits
  localparam int SCVOX_DEC_EN = 0;
  localparam int SCVOX_DEC_CS = 1;
  localparam int SCVOX_DEC_GAPSKIP = 2;
  localparam int SCVOX_DEC_CN = 3;
  localparam int SCVOX_DEC_SPEED = 4;
  localparam int SCVOX_DEC_SERIAL = 6;
  // flag bits
  localparam int SCVOX_FLAG_AVAIL = 0;
  localparam int SCVOX_FLAG_REQ = 1;
  // reset values
  localparam logic [13:0] SCVOX_RST_14 = 14'h0000;
  localparam logic [14:0] SCVOX_RST_15 = 15'h0000;
  localparam logic [10:0] SCVOX_RST_SEG_LEN = 11'h000;
  localparam logic [6:0] SCVOX_RST_DEC_CTRL = 7'h00;
  // speed codes in half steps: 1.0, 1.5, 2.0, 0.5
  localparam logic [1:0] SCVOX_SPD_1X0 = 2'h0;
  localparam logic [1:0] SCVOX_SPD_1X5 = 2'h1;
  localparam logic [1:0] SCVOX_SPD_2X0 = 2'h2;
  localparam logic [1:0] SCVOX_SPD_0X5 = 2'h3;
  // timing
  localparam int SCVOX_CLK_HZ = 200000000;
  localparam int SCVOX_SAMPLE_HZ = 8000;
  localparam int SCVOX_SLICE_MS = 9;
  localparam int SCVOX_SLICE_SAMPLES = SCVOX_SAMPLE_HZ * SCVOX_SLICE_MS / 1000;
  localparam int SCVOX_PCM_KBPS = 128;
  localparam int SCVOX_PCM_BITS = 16;
  localparam int SCVOX_SAMPLE_CYCLES =
    SCVOX_CLK_HZ / (SCVOX_PCM_KBPS * 1000 / SCVOX_PCM_BITS);
  localparam int SCVOX_GAP_BLOCK_MS = 30;
  localparam int SCVOX_GAP_BLOCK_CYCLES =
    SCVOX_CLK_HZ / 1000 * SCVOX_GAP_BLOCK_MS;
  localparam int SCVOX_TAIL_MS = 90;
  localparam int SCVOX_TAIL_BLOCKS = SCVOX_TAIL_MS / SCVOX_GAP_BLOCK_MS;
  // serial format overhead in bit/s
  localparam int SCVOX_OVH_FIXED_BPS = 400;
  localparam int SCVOX_OVH_VAR_BPS = 200;
endpackage : scvox_pkg

/* File: verilog/scvox_slice_power.sv */
// power of each 9 ms slice of the detector input
`timescale 1ns/1ps
`default_nettype none
module scvox_slice_power (
  input wire logic clk,
  input wire logic srst,
  input wire logic sample_valid,
  input wire logic [15:0] sample,
  output logic slice_valid,
  output logic [14:0] slice_power
);
  localparam int NS = scvox_pkg::SCVOX_SLICE_SAMPLES;
  localparam logic [7:0] LAST = 8'(NS - 1);

  logic [7:0] cnt_r;
  logic [38:0] acc_r;
  logic signed [15:0] s;
  logic [31:0] sq;
  logic [38:0] acc_nxt;
  logic last;

  assign s = sample;
  assign sq = 32'(s * s);
  assign acc_nxt = acc_r + {7'h00, sq};
  assign last = (cnt_r == LAST);

  // mean square, bits 37:23 kept; full scale reads 2400 hex
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_r <= 8'h00;
      acc_r <= 39'h0;
      slice_valid <= 1'b0;
      slice_power <= 15'h0000;
    end else begin
      slice_valid <= 1'b0;
      if (sample_valid) begin
        if (last) begin
          cnt_r <= 8'h00;
          acc_r <= 39'h0;
          slice_valid <= 1'b1;
          slice_power <= acc_nxt[37:23];
        end else begin
          cnt_r <= cnt_r + 8'h01;
          acc_r <= acc_nxt;
        end
      end
    end
  end
endmodule : scvox_slice_power
`default_nettype wire

/* File: verilog/scvox_ctrl.sv */
// vox detector, serial word transfer and decoder playback control
`timescale 1ns/1ps
`default_nettype none
module scvox_ctrl #(
  parameter int SAMPLE_CYCLES = scvox_pkg::SCVOX_SAMPLE_CYCLES,
  parameter int GAP_BLOCK_CYCLES = scvox_pkg::SCVOX_GAP_BLOCK_CYCLES
) (
  input wire logic clk,
  input wire logic srst,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  // detector input samples
  input wire logic det_sample_valid,
  input wire logic [15:0] det_sample,
  output logic noise_flag,
  // coder side
  input wire logic coder_word_valid,
  input wire logic [15:0] coder_word,
  // decoder side
  input wire logic dec_word_need,
  input wire logic dec_eof,
  input wire logic dec_gap_start,
  input wire logic dec_gap_end,
  output logic dec_word_valid,
  output logic [15:0] dec_word,
  output logic dec_enable,
  output logic serial_transfer_select,
  output logic [1:0] dec_speed,
  output logic pcm_tick,
  output logic consume_tick,
  output logic gap_fill,
  output logic gap_noise,
  output logic [14:0] gap_noise_level,
  output logic [1:0] tail_blocks
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [13:0] vox_frame_config_r;
  logic [13:0] vox_frame_thresholds_r;
  logic [14:0] vox_slice_energy_limit_r;
  logic [14:0] vox_spread_limit_r;
  logic [13:0] vox_segment_and_timer_r;
  logic [10:0] vox_segment_length_r;
  logic [6:0] decoder_control_r;
  logic [14:0] decoder_noise_level_r;
  logic [15:0] coder_output_word_r;
  logic data_available_flag_r;
  logic data_request_flag_r;

  logic [6:0] segments_per_frame;
  logic [6:0] min_adjacent_voice_segments;
  logic [6:0] max_quiet_segments;
  logic [6:0] min_voice_segments;
  logic [6:0] min_loud_slices;
  logic [6:0] vox_time;
  logic [10:0] slices_per_segment;
  logic [14:0] peak_spread_limit;

  assign segments_per_frame = vox_frame_config_r[scvox_pkg::SCVOX_LO7 +: 7];
  assign min_adjacent_voice_segments =
    vox_frame_config_r[scvox_pkg::SCVOX_HI7 +: 7];
  assign max_quiet_segments = vox_frame_thresholds_r[scvox_pkg::SCVOX_LO7 +: 7];
  assign min_voice_segments = vox_frame_thresholds_r[scvox_pkg::SCVOX_HI7 +: 7];
  assign min_loud_slices = vox_segment_and_timer_r[scvox_pkg::SCVOX_LO7 +: 7];
  assign vox_time = vox_segment_and_timer_r[scvox_pkg::SCVOX_HI7 +: 7];
  assign slices_per_segment = vox_segment_length_r;
  assign peak_spread_limit = vox_spread_limit_r;

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  logic wr_dec_ctrl;
  logic wr_dec_word;
  logic rd_coder_word;
  logic dec_running;
  logic speed_load;
  logic serial_mode;
  logic avail_set;
  logic req_set;

  assign wr_dec_ctrl = reg_wr && (reg_addr == scvox_pkg::SCVOX_IDX_DEC_CTRL);
  assign wr_dec_word = reg_wr && (reg_addr == scvox_pkg::SCVOX_IDX_DEC_WORD);
  assign rd_coder_word = reg_rd &&
    (reg_addr == scvox_pkg::SCVOX_IDX_CODER_WORD);
  assign dec_running = decoder_control_r[scvox_pkg::SCVOX_DEC_EN];
  assign serial_mode = decoder_control_r[scvox_pkg::SCVOX_DEC_SERIAL];
  // a running decoder only takes a new speed with the change bit set
  assign speed_load = wr_dec_ctrl &&
    (!dec_running || reg_wdata[scvox_pkg::SCVOX_DEC_CS]);
  assign avail_set = coder_word_valid && serial_mode;
  assign req_set = dec_word_need && serial_mode && dec_running;

  always_ff @(posedge clk) begin
    if (srst) begin
      vox_frame_config_r <= scvox_pkg::SCVOX_RST_14;
      vox_frame_thresholds_r <= scvox_pkg::SCVOX_RST_14;
      vox_slice_energy_limit_r <= scvox_pkg::SCVOX_RST_15;
      vox_spread_limit_r <= scvox_pkg::SCVOX_RST_15;
      vox_segment_and_timer_r <= scvox_pkg::SCVOX_RST_14;
      vox_segment_length_r <= scvox_pkg::SCVOX_RST_SEG_LEN;
      decoder_noise_level_r <= scvox_pkg::SCVOX_RST_15;
    end else if (reg_wr) begin
      case (reg_addr)
        scvox_pkg::SCVOX_IDX_FRAME_CFG: vox_frame_config_r <= reg_wdata[13:0];
        scvox_pkg::SCVOX_IDX_FRAME_THR: begin
          vox_frame_thresholds_r <= reg_wdata[13:0];
        end
        scvox_pkg::SCVOX_IDX_ENERGY: begin
          vox_slice_energy_limit_r <= reg_wdata[14:0];
        end
        scvox_pkg::SCVOX_IDX_SPREAD: vox_spread_limit_r <= reg_wdata[14:0];
        scvox_pkg::SCVOX_IDX_SEG_TIMER: begin
          vox_segment_and_timer_r <= reg_wdata[13:0];
        end
        scvox_pkg::SCVOX_IDX_SEG_LEN: begin
          vox_segment_length_r <= reg_wdata[10:0];
        end
        scvox_pkg::SCVOX_IDX_NOISE_LVL: begin
          decoder_noise_level_r <= reg_wdata[14:0];
        end
        default: ;
      endcase
    end
  end

  // decoder control: end of file wins over a host write of the enable
  logic [6:0] dec_ctrl_nxt;
  always_comb begin
    dec_ctrl_nxt = decoder_control_r;
    if (wr_dec_ctrl) begin
      dec_ctrl_nxt = reg_wdata[6:0];
      dec_ctrl_nxt[scvox_pkg::SCVOX_DEC_CS] = 1'b0;
      if (!speed_load) begin
        dec_ctrl_nxt[scvox_pkg::SCVOX_DEC_SPEED +: 2] =
          decoder_control_r[scvox_pkg::SCVOX_DEC_SPEED +: 2];
      end
    end
    if (dec_eof) begin
      dec_ctrl_nxt[scvox_pkg::SCVOX_DEC_EN] = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      decoder_control_r <= scvox_pkg::SCVOX_RST_DEC_CTRL;
    end else begin
      decoder_control_r <= dec_ctrl_nxt;
    end
  end

  // ----------------------------------------------------------------
  // word handshakes: a new event wins over a clear in the same cycle
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      coder_output_word_r <= 16'h0000;
      data_available_flag_r <= 1'b0;
      data_request_flag_r <= 1'b0;
      dec_word_valid <= 1'b0;
      dec_word <= 16'h0000;
    end else begin
      if (avail_set) begin
        coder_output_word_r <= coder_word;
      end
      data_available_flag_r <= avail_set ||
        (data_available_flag_r && !rd_coder_word);
      data_request_flag_r <= req_set ||
        (data_request_flag_r && !wr_dec_word);
      dec_word_valid <= wr_dec_word && data_request_flag_r;
      if (wr_dec_word) begin
        dec_word <= reg_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  logic [15:0] rd_mux;
  always_comb begin
    case (reg_addr)
      scvox_pkg::SCVOX_IDX_FRAME_CFG: rd_mux = {2'h0, vox_frame_config_r};
      scvox_pkg::SCVOX_IDX_FRAME_THR: rd_mux = {2'h0, vox_frame_thresholds_r};
      scvox_pkg::SCVOX_IDX_ENERGY: rd_mux = {1'b0, vox_slice_energy_limit_r};
      scvox_pkg::SCVOX_IDX_SPREAD: rd_mux = {1'b0, vox_spread_limit_r};
      scvox_pkg::SCVOX_IDX_SEG_TIMER: rd_mux = {2'h0, vox_segment_and_timer_r};
      scvox_pkg::SCVOX_IDX_SEG_LEN: rd_mux = {5'h00, vox_segment_length_r};
      scvox_pkg::SCVOX_IDX_DEC_CTRL: rd_mux = {9'h000, decoder_control_r};
      scvox_pkg::SCVOX_IDX_FLAGS: begin
        rd_mux = {14'h0000, data_request_flag_r, data_available_flag_r};
      end
      scvox_pkg::SCVOX_IDX_CODER_WORD: rd_mux = coder_output_word_r;
      scvox_pkg::SCVOX_IDX_NOISE_LVL: rd_mux = {1'b0, decoder_noise_level_r};
      scvox_pkg::SCVOX_IDX_VOX_STATUS: rd_mux = {15'h0000, noise_flag};
      default: rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // slice and segment level
  // ----------------------------------------------------------------
  logic slice_valid;
  logic [14:0] slice_power;

  scvox_slice_power u_slice (
    .clk(clk),
    .srst(srst),
    .sample_valid(det_sample_valid),
    .sample(det_sample),
    .slice_valid(slice_valid),
    .slice_power(slice_power)
  );

  logic [10:0] slice_cnt_r;
  logic [14:0] pmax_r;
  logic [14:0] pmin_r;
  logic [10:0] loud_cnt_r;
  logic seg_first;
  logic seg_last;
  logic [14:0] pmax_nxt;
  logic [14:0] pmin_nxt;
  logic [10:0] loud_nxt;
  logic [14:0] spread;
  logic seg_voice;

  assign seg_first = (slice_cnt_r == 11'h000);
  // zero length behaves as one slice so segments never stall
  assign seg_last = (slice_cnt_r + 11'h001 >= slices_per_segment);
  assign pmax_nxt = (seg_first || slice_power > pmax_r) ? slice_power : pmax_r;
  assign pmin_nxt = (seg_first || slice_power < pmin_r) ? slice_power : pmin_r;
  assign loud_nxt = (seg_first ? 11'h000 : loud_cnt_r) +
    ((slice_power > vox_slice_energy_limit_r) ? 11'h001 : 11'h000);
  assign spread = pmax_nxt - pmin_nxt;
  // quiet if too few loud slices or too flat; voice otherwise
  assign seg_voice = (loud_nxt >= {4'h0, min_loud_slices}) &&
    (spread >= peak_spread_limit);

  always_ff @(posedge clk) begin
    if (srst) begin
      slice_cnt_r <= 11'h000;
      pmax_r <= 15'h0000;
      pmin_r <= 15'h0000;
      loud_cnt_r <= 11'h000;
    end else if (slice_valid) begin
      pmax_r <= pmax_nxt;
      pmin_r <= pmin_nxt;
      loud_cnt_r <= loud_nxt;
      slice_cnt_r <= seg_last ? 11'h000 : slice_cnt_r + 11'h001;
    end
  end

  logic seg_done;
  assign seg_done = slice_valid && seg_last;

  // ----------------------------------------------------------------
  // frame level
  // ----------------------------------------------------------------
  logic [6:0] seg_cnt_r;
  logic [6:0] quiet_cnt_r;
  logic [6:0] voice_cnt_r;
  logic [6:0] run_r;
  logic [6:0] timer_r;
  logic noise_r;
  logic [6:0] run_nxt;
  logic [6:0] quiet_nxt;
  logic [6:0] voice_nxt;
  logic adj_hit;
  logic frame_end;
  logic frame_voice;

  assign run_nxt = seg_voice ? run_r + 7'h01 : 7'h00;
  assign quiet_nxt = quiet_cnt_r + (seg_voice ? 7'h00 : 7'h01);
  assign voice_nxt = voice_cnt_r + (seg_voice ? 7'h01 : 7'h00);
  assign adj_hit = seg_voice && (run_nxt >= min_adjacent_voice_segments);
  assign frame_end = (seg_cnt_r + 7'h01 >= segments_per_frame);
  assign frame_voice = (quiet_nxt <= max_quiet_segments) &&
    (voice_nxt >= min_voice_segments);

  always_ff @(posedge clk) begin
    if (srst) begin
      seg_cnt_r <= 7'h00;
      quiet_cnt_r <= 7'h00;
      voice_cnt_r <= 7'h00;
      run_r <= 7'h00;
      timer_r <= 7'h00;
      noise_r <= 1'b0;
    end else if (seg_done) begin
      if (adj_hit || frame_end) begin
        seg_cnt_r <= 7'h00;
        quiet_cnt_r <= 7'h00;
        voice_cnt_r <= 7'h00;
        run_r <= 7'h00;
      end else begin
        seg_cnt_r <= seg_cnt_r + 7'h01;
        quiet_cnt_r <= quiet_nxt;
        voice_cnt_r <= voice_nxt;
        run_r <= run_nxt;
      end
      if (adj_hit) begin
        noise_r <= 1'b0;
        timer_r <= 7'h00;
      end else if (frame_end && frame_voice) begin
        noise_r <= 1'b0;
        timer_r <= 7'h00;
      end else if (frame_end) begin
        // timer saturates so a long noise spell keeps the flag set
        if (timer_r != 7'h7F) begin
          timer_r <= timer_r + 7'h01;
        end
        if (timer_r + 7'h01 >= vox_time) begin
          noise_r <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // playback pacing and gap replay
  // ----------------------------------------------------------------
  localparam int SC = SAMPLE_CYCLES;
  localparam logic [19:0] PCM_LAST = 20'(SC - 1);
  logic [19:0] pcm_cnt_r;
  logic [20:0] use_cnt_r;
  logic [20:0] use_last;
  logic [1:0] spd;
  logic [24:0] gap_cnt_r;
  logic gap_r;
  logic gap_timeout;

  assign spd = decoder_control_r[scvox_pkg::SCVOX_DEC_SPEED +: 2];
  // input words are drawn faster or slower than the output samples
  always_comb begin
    case (spd)
      scvox_pkg::SCVOX_SPD_1X5: use_last = 21'(SC * 2 / 3 - 1);
      scvox_pkg::SCVOX_SPD_2X0: use_last = 21'(SC / 2 - 1);
      scvox_pkg::SCVOX_SPD_0X5: use_last = 21'(SC * 2 - 1);
      default: use_last = 21'(SC - 1);
    endcase
  end
  assign gap_timeout = decoder_control_r[scvox_pkg::SCVOX_DEC_GAPSKIP] &&
    (gap_cnt_r == 25'(GAP_BLOCK_CYCLES - 1));

  always_ff @(posedge clk) begin
    if (srst || !dec_running) begin
      pcm_cnt_r <= 20'h00000;
      use_cnt_r <= 21'h000000;
      pcm_tick <= 1'b0;
      consume_tick <= 1'b0;
    end else begin
      pcm_tick <= (pcm_cnt_r == PCM_LAST);
      pcm_cnt_r <= (pcm_cnt_r == PCM_LAST) ? 20'h00000 : pcm_cnt_r + 20'h1;
      consume_tick <= (use_cnt_r >= use_last);
      use_cnt_r <= (use_cnt_r >= use_last) ? 21'h000000 : use_cnt_r + 21'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst || !dec_running) begin
      gap_r <= 1'b0;
      gap_cnt_r <= 25'h0000000;
    end else if (dec_gap_start) begin
      gap_r <= 1'b1;
      gap_cnt_r <= 25'h0000000;
    end else if (gap_r) begin
      gap_cnt_r <= gap_cnt_r + 25'h1;
      if (gap_timeout || dec_gap_end) begin
        gap_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // output registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      noise_flag <= 1'b0;
      dec_enable <= 1'b0;
      serial_transfer_select <= 1'b0;
      dec_speed <= scvox_pkg::SCVOX_SPD_1X0;
      gap_fill <= 1'b0;
      gap_noise <= 1'b0;
      gap_noise_level <= scvox_pkg::SCVOX_RST_15;
      tail_blocks <= 2'h0;
    end else begin
      noise_flag <= noise_r;
      dec_enable <= dec_ctrl_nxt[scvox_pkg::SCVOX_DEC_EN];
      serial_transfer_select <= serial_mode;
      dec_speed <= spd;
      gap_fill <= gap_r;
      gap_noise <= gap_r &&
        decoder_control_r[scvox_pkg::SCVOX_DEC_CN];
      gap_noise_level <= decoder_noise_level_r;
      tail_blocks <= 2'(scvox_pkg::SCVOX_TAIL_BLOCKS);
    end
  end
endmodule : scvox_ctrl
`default_nettype wire

/* File: testbench/scvox_ctrl_monitor.sv */
// concurrent checks on the block ports
`timescale 1ns/1ps
`default_nettype none
module scvox_monitor #(
  parameter int SAMPLE_CYCLES = 20
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [3:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic noise_flag,
  input wire logic dec_eof,
  input wire logic dec_word_valid,
  input wire logic [15:0] dec_word,
  input wire logic dec_enable,
  input wire logic [1:0] dec_speed,
  input wire logic pcm_tick,
  input wire logic gap_fill,
  input wire logic gap_noise,
  input wire logic [1:0] tail_blocks
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  // ----
  // helpers and properties
  // ----
  // cycles since last output sample
  logic [15:0] since_r;
  logic seen_r;
  always_ff @(posedge clk) begin
    since_r <= (srst || pcm_tick) ? 16'h0000 : since_r + 16'h0001;
    seen_r <= !srst && (seen_r || pcm_tick);
  end
  property speed_p;
    logic [1:0] v;
    (reg_wr && reg_addr == 4'h6 && reg_wdata[1], v = reg_wdata[5:4])
      |-> ##3 dec_speed == v;
  endproperty
  reset_clear_a: assert property (
    $fell(srst) |-> !noise_flag && !dec_enable && !dec_word_valid)
    else $error("reset left outputs set");
  tail_const_a: assert property (
    $past(!srst) |-> tail_blocks == 2'h3)
    else $error("tail block count wrong");
  eof_disable_a: assert property (
    dec_eof |-> ##[1:2] !dec_enable)
    else $error("end of file left decoder on");
  word_deliver_a: assert property (
    dec_word_valid |-> $past(reg_wr) && $past(reg_addr) == 4'hA
      && dec_word == $past(reg_wdata))
    else $error("word without write");
  rdata_hold_a: assert property (
    !reg_rd && !$past(reg_rd) |=> $stable(reg_rdata))
    else $error("read data moved without read");
  speed_hold_a: assert property (
    dec_enable && reg_wr && reg_addr == 4'h6 && !reg_wdata[1]
      |=> $stable(dec_speed) [*2])
    else $error("speed changed without change bit");
  speed_set_a: assert property (speed_p)
    else $error("speed not taken");
  pcm_pace_a: assert property (
    pcm_tick && seen_r |-> since_r >= 16'(SAMPLE_CYCLES - 1))
    else $error("output samples too close");
  gap_noise_a: assert property (
    gap_noise |-> gap_fill)
    else $error("noise outside gap replay");
  word_c: cover property (dec_word_valid);
  eof_c: cover property (dec_eof ##1 !dec_enable);
  noise_c: cover property ($rose(noise_flag));
  gap_c: cover property ($rose(gap_fill));
endmodule : scvox_monitor
bind scvox_ctrl scvox_monitor #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) u_mon (
  .clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .noise_flag(noise_flag), .dec_eof(dec_eof),
  .dec_word_valid(dec_word_valid), .dec_word(dec_word),
  .dec_enable(dec_enable), .dec_speed(dec_speed), .pcm_tick(pcm_tick),
  .gap_fill(gap_fill), .gap_noise(gap_noise), .tail_blocks(tail_blocks));
`default_nettype wire

/* File: testbench/scvox_host.sv */
// host model on the register port
`timescale 1ns/1ps
`default_nettype none
module scvox_host (
  input wire logic clk,
  output logic [3:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata
);
  // ----
  // bus cycles
  // ----
  initial {reg_addr, reg_wr, reg_rd, reg_wdata} = 22'h000000;
  // idle data inverted so stale data never looks valid
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    #1 d = reg_rdata;
  endtask : rd
  task automatic drain(output int n, output logic [15:0] w);
    logic [15:0] f;
    n = 0;
    rd(4'h7, f);
    while (f[0] === 1'b1 && n < 8) begin
      rd(4'h8, w);
      n++;
      rd(4'h7, f);
    end
  endtask : drain
endmodule : scvox_host
`default_nettype wire

/* File: testbench/tb_scvox_ctrl.sv */
// self-checking bench for the vox control block
`timescale 1ns/1ps
`default_nettype none
module tb_scvox_ctrl;
  localparam int SC = 20;
  localparam int GB = 50;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [5:0] ev = 6'h00;
  logic [15:0] det_sample = 16'h0000;
  logic [15:0] coder_word = 16'h0000;
  logic [3:0] reg_addr;
  logic reg_wr, reg_rd, noise_flag, dec_word_valid, dec_enable, sts;
  logic pcm_tick, gap_fill, gap_noise, ct;
  logic [15:0] reg_wdata, reg_rdata, dec_word, d, last_dw;
  logic [14:0] gnl;
  logic [1:0] dec_speed, tail_blocks;
  int failures = 0, check_count = 0, nvalid = 0, nfill = 0, ntick = 0;
  int n, t0, ncons = 0;
  logic [35:0] rows [12] = '{36'h0FFFF3FFF, 36'h1FFFF3FFF,
    36'h2FFFF7FFF, 36'h3FFFF7FFF, 36'h4FFFF3FFF, 36'h5FFFF07FF,
    36'h600760074, 36'h7FFFF0000, 36'h8FFFF0000, 36'h9FFFF7FFF,
    36'hCFFFF0000, 36'hF12340000};
  logic [15:0] vc [6] = '{16'h0081, 16'h0080, 16'h0100, 16'h0400,
    16'h0101, 16'h0002};
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    nvalid <= nvalid + (dec_word_valid === 1'b1);
    nfill <= nfill + (gap_fill === 1'b1);
    ntick <= ntick + (pcm_tick === 1'b1);
    ncons <= ncons + (ct === 1'b1);
    if (dec_word_valid === 1'b1) last_dw <= dec_word;
  end
  scvox_ctrl #(.SAMPLE_CYCLES(SC), .GAP_BLOCK_CYCLES(GB)) uut (
    .clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .det_sample_valid(ev[5]), .det_sample(det_sample),
    .noise_flag(noise_flag), .coder_word_valid(ev[0]),
    .coder_word(coder_word), .dec_word_need(ev[1]), .dec_eof(ev[2]),
    .dec_gap_start(ev[3]), .dec_gap_end(ev[4]),
    .dec_word_valid(dec_word_valid), .dec_word(dec_word),
    .dec_enable(dec_enable), .serial_transfer_select(sts),
    .dec_speed(dec_speed), .pcm_tick(pcm_tick), .consume_tick(ct),
    .gap_fill(gap_fill), .gap_noise(gap_noise), .gap_noise_level(gnl),
    .tail_blocks(tail_blocks));
  scvox_host host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  // ----
  // helpers
  // ----
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic pulse(input int i);
    @(posedge clk) ev[i] <= 1'b1;
    @(posedge clk) ev[i] <= 1'b0;
  endtask : pulse
  task automatic slice(input logic [15:0] a);
    repeat (72) begin
      @(posedge clk) det_sample <= a;
      ev[5] <= 1'b1;
      @(posedge clk) ev[5] <= 1'b0;
      det_sample <= ~a;
    end
  endtask : slice
  task automatic seg_check(input logic [15:0] a, b, input logic f);
    slice(a);
    slice(b);
    repeat (20) @(posedge clk);
    host.rd(4'hB, d);
    check({d[14:0], noise_flag}, {14'h0, f, f});
  endtask : seg_check
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : stop_test
  initial begin
    #(5ns * 30000);
    failures++;
    stop_test();
  end
  initial begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    foreach (rows[i]) begin
      host.rd(rows[i][35:32], d);
      check(d, 16'h0000);
      host.wr(rows[i][35:32], rows[i][31:16]);
      host.rd(rows[i][35:32], d);
      check(d, rows[i][15:0]);
    end
    check({14'h0, dec_speed}, 16'h0003);
    $display("register test done");
    host.wr(4'h6, 16'h0040);
    @(posedge clk) coder_word <= 16'hBEEF;
    pulse(0);
    host.drain(n, d);
    check(16'(n), 16'h0001);
    check(d, 16'hBEEF);
    check({15'h0, sts}, 16'h0001);
    host.wr(4'h6, 16'h0041);
    pulse(1);
    host.rd(4'h7, d);
    check(d, 16'h0002);
    host.wr(4'hA, 16'h1234);
    host.wr(4'hA, 16'h5678);
    host.rd(4'h7, d);
    check(d, 16'h0000);
    check(16'(nvalid), 16'h0001);
    check(last_dw, 16'h1234);
    $display("transfer test done");
    t0 = ntick;
    repeat (SC * 10) @(posedge clk);
    check(16'(ntick - t0), 16'h000A);
    for (int s = 1; s < 4; s++) begin
      host.wr(4'h6, 16'h0043 | 16'(s << 4));
      repeat (4) @(posedge clk);
      check({14'h0, dec_speed}, 16'(s));
    end
    host.wr(4'h6, 16'h0041);
    t0 = ncons;
    repeat (SC * 8) @(posedge clk);
    check({14'h0, dec_speed}, 16'h0003);
    check(16'(ncons - t0), 16'h0004);
    host.wr(4'h9, 16'h0123);
    host.wr(4'h6, 16'h004D);
    t0 = nfill;
    pulse(3);
    repeat (5) @(posedge clk);
    check({15'h0, gap_noise}, 16'h0001);
    check({1'b0, gnl}, 16'h0123);
    repeat (GB + 20) @(posedge clk);
    pulse(4);
    check(16'(nfill - t0), 16'(GB));
    pulse(2);
    repeat (3) @(posedge clk);
    host.rd(4'h6, d);
    check(d, 16'h007C);
    check({14'h0, tail_blocks}, 16'h0003);
    $display("playback test done");
    foreach (vc[i]) host.wr(4'(i), vc[i]);
    seg_check(16'h4000, 16'h4000, 1'b0);
    seg_check(16'h4000, 16'h4000, 1'b1);
    seg_check(16'h4000, 16'h0000, 1'b0);
    seg_check(16'h0000, 16'h0000, 1'b0);
    seg_check(16'h0000, 16'h0000, 1'b1);
    $display("detector test done");
    @(posedge clk) srst <= 1'b1;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    host.rd(4'h7, d);
    check(d | {15'h0, noise_flag | dec_enable}, 16'h0000);
    $display("reset test done");
    stop_test();
  end
endmodule : tb_scvox_ctrl
`default_nettype wire
